// File: sdr_map.svh
`ifndef SDR_MAP_SVH
`define SDR_MAP_SVH

// ----------------------------------------------------------------
// Register indices, byte address is four times the index
// ----------------------------------------------------------------
`define SDR_IDX_CTRL      3'h0
`define SDR_IDX_STAT      3'h3
`define SDR_IDX_DHI       3'h4
`define SDR_IDX_DLO       3'h5
`define SDR_IDX_IRQ       3'h6
`define SDR_IDX_MASK      3'h7

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SDR_CTRL_EN       0
`define SDR_CTRL_MSTR     1
`define SDR_CTRL_BAUD_LO  4
`define SDR_CTRL_BAUD_HI  7
`define SDR_STAT_RCF      7
`define SDR_STAT_TEF      5
`define SDR_STAT_HELD     0
`define SDR_EV_RX         0
`define SDR_EV_TX         1
`define SDR_EV_DROP       2

// ----------------------------------------------------------------
// Reset values and timing counts
// ----------------------------------------------------------------
`define SDR_RESET_BYTE    8'h00
`define SDR_RESET_WORD    16'h0000
`define SDR_HALF_EXTRA    5'h03
`define SDR_LAST_BIT      5'h0f

`endif

// File: sdr_pkg.sv
package sdr_pkg;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic {ST_IDLE, ST_RUN} sdr_state_t;

    typedef struct packed {
        logic sck;
        logic mosi;
        logic miso;
        logic ss_n;
    } sdr_pin_in_t;

    typedef struct packed {
        logic sck;
        logic sck_oe_n;
        logic mosi;
        logic mosi_oe_n;
        logic miso;
        logic miso_oe_n;
        logic ss_n;
    } sdr_pin_out_t;

endpackage

// File: sdr_spi_data.sv
// What this block does
// - Sixteen-bit data register, two byte halves, reset zero
// - Master starts queued data after current transfer
// - Empty flag shows register accepts new data
// - Frame copied, flag set when flag clear
// - Second frame held, data register unchanged
// - Serviced before third start: held frame moves
// - Serviced after third start: held frame dropped

`include "sdr_map.svh"

module sdr_spi_data (
    // Clock and reset
    input  wire logic                 clock,
    input  wire logic                 resetn,
    // AHB-Lite slave
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic                      hreadyout,
    output logic                      hresp,
    output logic [31:0]               hrdata,
    // Serial pins
    input  wire sdr_pkg::sdr_pin_in_t pin_in,
    output sdr_pkg::sdr_pin_out_t     pin_out,
    // Interrupt
    output logic                      irq
);
    import sdr_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [7:0]   ctrl_reg;
    logic [7:0]   tx_hi_reg;
    logic [15:0]  tx_buf_reg;
    logic [15:0]  data_rx_reg;
    logic [15:0]  held_reg;
    logic         held_valid_reg;
    logic         rcf_reg;
    logic         tef_reg;
    logic         armed_reg;
    logic [2:0]   irq_stat_reg;
    logic [2:0]   irq_stat_next;
    logic [2:0]   irq_mask_reg;
    logic         irq_reg;
    logic         wr_pend_reg;
    logic [2:0]   wr_idx_reg;
    logic [31:0]  hrdata_reg;
    logic         hreadyout_reg;
    sdr_state_t   state_reg;
    logic [15:0]  shift_reg;
    logic         sample_reg;
    logic [4:0]   bit_cnt_reg;
    logic [4:0]   div_cnt_reg;
    sdr_pin_out_t pin_out_reg;
    sdr_pin_in_t  pin_meta_reg;
    sdr_pin_in_t  pin_sync_reg;
    logic         sck_prev_reg;
    logic         ss_prev_reg;

    logic         addr_ok;
    logic         rd_now;
    logic         rd_stat;
    logic         rd_dlo;
    logic         rd_irq;
    logic         svc;
    logic         wr_ctrl;
    logic         wr_dhi;
    logic         wr_dlo;
    logic         wr_mask;
    logic         enabled;
    logic         master;
    logic         xfer_start;
    logic         rise_ev;
    logic         fall_ev;
    logic         frame_done;
    logic [15:0]  frame_data;
    logic         take_frame;
    logic         move_held;
    logic         drop_held;
    logic [2:0]   events;
    logic [7:0]   rd_value;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    function automatic logic [2:0] word_idx(input logic [31:0] a);
        return a[4:2];
    endfunction

    function automatic logic is_mapped(input logic [31:0] a);
        logic [2:0] i;
        i = a[4:2];
        return (a[31:5] == 27'h0000000) && (a[1:0] == 2'h0) &&
               (i == `SDR_IDX_CTRL || i == `SDR_IDX_STAT || i == `SDR_IDX_DHI ||
                i == `SDR_IDX_DLO || i == `SDR_IDX_IRQ || i == `SDR_IDX_MASK);
    endfunction

    assign addr_ok = hsel & htrans[1] & hready;
    assign rd_now  = addr_ok & ~hwrite & is_mapped(haddr);
    assign rd_stat = rd_now & (word_idx(haddr) == `SDR_IDX_STAT);
    assign rd_dlo  = rd_now & (word_idx(haddr) == `SDR_IDX_DLO);
    assign rd_irq  = rd_now & (word_idx(haddr) == `SDR_IDX_IRQ);
    assign svc     = rd_dlo & armed_reg;
    assign wr_ctrl = wr_pend_reg & (wr_idx_reg == `SDR_IDX_CTRL);
    assign wr_dhi  = wr_pend_reg & (wr_idx_reg == `SDR_IDX_DHI);
    assign wr_dlo  = wr_pend_reg & (wr_idx_reg == `SDR_IDX_DLO);
    assign wr_mask = wr_pend_reg & (wr_idx_reg == `SDR_IDX_MASK);
    assign enabled = ctrl_reg[`SDR_CTRL_EN];
    assign master  = ctrl_reg[`SDR_CTRL_MSTR];

    always_comb begin
        case (word_idx(haddr))
            `SDR_IDX_CTRL: rd_value = ctrl_reg;
            `SDR_IDX_STAT: rd_value = {rcf_reg, 1'b0, tef_reg, 4'h0, held_valid_reg};
            `SDR_IDX_DHI:  rd_value = data_rx_reg[15:8];
            `SDR_IDX_DLO:  rd_value = data_rx_reg[7:0];
            `SDR_IDX_IRQ:  rd_value = {5'h00, irq_stat_reg};
            `SDR_IDX_MASK: rd_value = {5'h00, irq_mask_reg};
            default:       rd_value = 8'h00;
        endcase
    end

    // ------------------------------------------------------------
    // Bus slave, zero wait states
    // ------------------------------------------------------------
    // Read data is sampled in the address phase, so a read right
    // behind a write to the same register sees the old value.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            wr_pend_reg   <= 1'b0;
            wr_idx_reg    <= 3'h0;
            hrdata_reg    <= 32'h00000000;
            hreadyout_reg <= 1'b0;
        end else begin
            wr_pend_reg   <= addr_ok & hwrite & is_mapped(haddr);
            wr_idx_reg    <= word_idx(haddr);
            hrdata_reg    <= rd_now ? {24'h000000, rd_value} : 32'h00000000;
            hreadyout_reg <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Control and transmit side
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ctrl_reg     <= `SDR_RESET_BYTE;
            irq_mask_reg <= 3'h0;
            tx_hi_reg    <= `SDR_RESET_BYTE;
            tx_buf_reg   <= `SDR_RESET_WORD;
        end else begin
            if (wr_ctrl)
                ctrl_reg <= hwdata[7:0];
            if (wr_mask)
                irq_mask_reg <= hwdata[2:0];
            if (wr_dhi)
                tx_hi_reg <= hwdata[7:0];
            if (wr_dlo)
                tx_buf_reg <= {tx_hi_reg, hwdata[7:0]};
        end
    end

    // Low-byte write queues the word; a write in the start cycle
    // is a new word, so it leaves the flag clear.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            tef_reg <= 1'b1;
        end else if (wr_dlo) begin
            tef_reg <= 1'b0;
        end else if (xfer_start) begin
            tef_reg <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Receive side
    // ------------------------------------------------------------
    assign take_frame = frame_done & (~rcf_reg | (svc & ~held_valid_reg));
    assign move_held  = svc & held_valid_reg;
    assign drop_held  = xfer_start & held_valid_reg & ~svc;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            armed_reg <= 1'b0;
        end else if (rd_stat) begin
            armed_reg <= rcf_reg;
        end else if (rd_dlo) begin
            armed_reg <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            data_rx_reg    <= `SDR_RESET_WORD;
            held_reg       <= `SDR_RESET_WORD;
            held_valid_reg <= 1'b0;
            rcf_reg        <= 1'b0;
        end else if (take_frame) begin
            data_rx_reg <= frame_data;
            rcf_reg     <= 1'b1;
        end else if (move_held) begin
            data_rx_reg    <= held_reg;
            held_valid_reg <= 1'b0;
        end else if (frame_done) begin
            held_reg       <= frame_data;
            held_valid_reg <= 1'b1;
        end else if (drop_held) begin
            held_valid_reg <= 1'b0;
        end else if (svc) begin
            rcf_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    assign events = {drop_held, xfer_start, take_frame | move_held};

    always_comb begin
        irq_stat_next = (rd_irq ? 3'h0 : irq_stat_reg) | events;
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            irq_stat_reg <= 3'h0;
            irq_reg      <= 1'b0;
        end else begin
            irq_stat_reg <= irq_stat_next;
            irq_reg      <= |(irq_stat_next & irq_mask_reg);
        end
    end

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pin_meta_reg <= '{sck: 1'b0, mosi: 1'b0, miso: 1'b0, ss_n: 1'b1};
            pin_sync_reg <= '{sck: 1'b0, mosi: 1'b0, miso: 1'b0, ss_n: 1'b1};
            sck_prev_reg <= 1'b0;
            ss_prev_reg  <= 1'b1;
        end else begin
            pin_meta_reg <= pin_in;
            pin_sync_reg <= pin_meta_reg;
            sck_prev_reg <= pin_sync_reg.sck;
            ss_prev_reg  <= pin_sync_reg.ss_n;
        end
    end

    // ------------------------------------------------------------
    // Shift engine, clock idle low, sample on rise, shift on fall
    // ------------------------------------------------------------
    // Half period is baud plus four cycles so the synchronised
    // input has settled before the master samples it.
    always_comb begin
        xfer_start = 1'b0;
        rise_ev    = 1'b0;
        fall_ev    = 1'b0;
        if (enabled && state_reg == ST_IDLE) begin
            if (master)
                xfer_start = ~tef_reg;
            else
                xfer_start = ss_prev_reg & ~pin_sync_reg.ss_n;
        end
        if (state_reg == ST_RUN) begin
            if (master) begin
                rise_ev = (div_cnt_reg == ({1'b0, ctrl_reg[`SDR_CTRL_BAUD_HI:`SDR_CTRL_BAUD_LO]} + `SDR_HALF_EXTRA))
                          & ~pin_out_reg.sck;
                fall_ev = (div_cnt_reg == ({1'b0, ctrl_reg[`SDR_CTRL_BAUD_HI:`SDR_CTRL_BAUD_LO]} + `SDR_HALF_EXTRA))
                          & pin_out_reg.sck;
            end else begin
                rise_ev = pin_sync_reg.sck & ~sck_prev_reg;
                fall_ev = ~pin_sync_reg.sck & sck_prev_reg;
            end
        end
    end

    assign frame_data = {shift_reg[14:0], sample_reg};
    assign frame_done = fall_ev & (bit_cnt_reg == `SDR_LAST_BIT);

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_reg   <= ST_IDLE;
            shift_reg   <= `SDR_RESET_WORD;
            sample_reg  <= 1'b0;
            bit_cnt_reg <= 5'h00;
            div_cnt_reg <= 5'h00;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    div_cnt_reg <= 5'h00;
                    if (xfer_start) begin
                        shift_reg   <= tx_buf_reg;
                        bit_cnt_reg <= 5'h00;
                        state_reg   <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    div_cnt_reg <= (rise_ev | fall_ev) ? 5'h00 : div_cnt_reg + 5'h01;
                    if (rise_ev)
                        sample_reg <= master ? pin_sync_reg.miso : pin_sync_reg.mosi;
                    if (fall_ev) begin
                        shift_reg   <= frame_data;
                        bit_cnt_reg <= bit_cnt_reg + 5'h01;
                    end
                    // Slave deselected mid-frame or block disabled aborts
                    if (frame_done || !enabled || (!master && pin_sync_reg.ss_n))
                        state_reg <= ST_IDLE;
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pin_out_reg <= '{sck: 1'b0, sck_oe_n: 1'b1, mosi: 1'b0, mosi_oe_n: 1'b1,
                             miso: 1'b0, miso_oe_n: 1'b1, ss_n: 1'b1};
        end else begin
            pin_out_reg.sck_oe_n  <= ~(enabled & master);
            pin_out_reg.mosi_oe_n <= ~(enabled & master);
            pin_out_reg.miso_oe_n <= ~(enabled & ~master & ~pin_sync_reg.ss_n);
            if (xfer_start) begin
                pin_out_reg.mosi <= tx_buf_reg[15];
                pin_out_reg.miso <= tx_buf_reg[15];
                pin_out_reg.ss_n <= ~master;
            end else if (fall_ev) begin
                pin_out_reg.mosi <= shift_reg[14];
                pin_out_reg.miso <= shift_reg[14];
            end
            if (master && (rise_ev || fall_ev))
                pin_out_reg.sck <= ~pin_out_reg.sck;
            if (state_reg == ST_RUN && (frame_done || !enabled)) begin
                pin_out_reg.ss_n <= 1'b1;
                pin_out_reg.sck  <= 1'b0;
            end
        end
    end

    assign hreadyout = hreadyout_reg;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_reg;
    assign pin_out   = pin_out_reg;
    assign irq       = irq_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    chk_tx_queue: assert property (
        wr_dlo |=> (tx_buf_reg[7:0] == $past(hwdata[7:0])) && !tef_reg)
        else $error("low byte write did not queue data");

    chk_master_start: assert property (
        (state_reg == ST_IDLE && enabled && master && !tef_reg)
        |=> state_reg == ST_RUN ##0 (shift_reg == $past(tx_buf_reg)))
        else $error("master did not start queued word");

    chk_empty_flag: assert property (
        (xfer_start && !wr_dlo) |=> tef_reg [*1] ##0 (state_reg == ST_RUN))
        else $error("empty flag not raised on start");

    chk_rx_copy: assert property (
        (frame_done && !rcf_reg) |=> rcf_reg && (data_rx_reg == $past(frame_data)))
        else $error("received frame not copied");

    chk_rx_hold: assert property (
        (frame_done && rcf_reg && !svc && !held_valid_reg)
        |=> held_valid_reg && $stable(data_rx_reg) && (held_reg == $past(frame_data)))
        else $error("second frame not held");

    chk_held_move: assert property (
        (svc && held_valid_reg) |=> rcf_reg && !held_valid_reg && (data_rx_reg == $past(held_reg)))
        else $error("held frame not moved on service");

    chk_held_drop: assert property (
        (xfer_start && held_valid_reg && !svc) |=> !held_valid_reg && $stable(data_rx_reg)
        ##1 (irq_stat_reg[`SDR_EV_DROP] || $past(rd_irq)))
        else $error("held frame not dropped on new start");

    chk_service_clear: assert property (
        (rd_dlo && armed_reg && !held_valid_reg && !frame_done) |=> !rcf_reg)
        else $error("service did not clear flag");

    chk_irq_level: assert property (
        (|(irq_stat_next & irq_mask_reg)) |=> irq)
        else $error("interrupt not raised");

endmodule

// File: sdr_peer.sv
module sdr_peer #(
    parameter logic [15:0] REPLY_BASE = 16'h5a00,
    parameter logic [15:0] REPLY_STEP = 16'h0101
) (
    // Serial lines
    input  wire logic sck,
    input  wire logic ss_n,
    input  wire logic mosi,
    output logic      miso,
    // Master side, used while the block is a slave
    input  wire logic miso_line,
    output logic      drv_sck,
    output logic      drv_ss_n,
    output logic      drv_mosi,
    // Observation
    output logic [15:0] last_rx,
    output int          frames
);
    timeunit 1ns;
    timeprecision 1ns;

    // ------------------------------------------------------------
    // Mode 0 slave, reply word steps with each frame
    // ------------------------------------------------------------
    logic [15:0] tx_sr;
    logic [15:0] rx_sr;
    logic        active;

    initial begin
        miso    = 1'b0;
        last_rx = 16'h0000;
        frames  = 0;
        tx_sr   = 16'h0000;
        rx_sr   = 16'h0000;
        active  = 1'b0;
        drv_sck  = 1'b0;
        drv_ss_n = 1'b1;
        drv_mosi = 1'b0;
    end

    // Mode 0 master frame, half period of eight block clocks
    task automatic master_frame(input logic [15:0] w, output logic [15:0] r);
        #5 drv_mosi = w[15];
        drv_ss_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            #160 drv_sck = 1'b1;
            r[i] = miso_line;
            #160 drv_sck = 1'b0;
            if (i > 0)
                drv_mosi = w[i-1];
        end
        #160 drv_ss_n = 1'b1;
    endtask

    always @(negedge ss_n) begin
        active = 1'b1;
        tx_sr  = REPLY_BASE + REPLY_STEP * frames[15:0];
        miso   = tx_sr[15];
    end

    always @(posedge sck) begin
        if (!ss_n && active) begin
            rx_sr = {rx_sr[14:0], mosi};
        end
    end

    always @(negedge sck) begin
        if (!ss_n && active) begin
            tx_sr = {tx_sr[14:0], 1'b0};
            miso  = tx_sr[15];
        end
    end

    // Released line has no pull, so it must not keep the last bit
    always @(posedge ss_n) begin
        if (active) begin
            active  = 1'b0;
            last_rx = rx_sr;
            frames  = frames + 1;
            miso    = ~miso;
        end
    end
endmodule

// File: sdr_spi_data_bench.sv
`include "sdr_map.svh"

module sdr_spi_data_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import sdr_pkg::*;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic               clock;
    logic               resetn;
    logic               hsel;
    logic               hwrite;
    logic               hreadyout;
    logic               hresp;
    logic               irq;
    logic [1:0]         htrans;
    logic [2:0]         hsize;
    logic [31:0]        haddr;
    logic [31:0]        hwdata;
    logic [31:0]        hrdata;
    sdr_pin_in_t        pin_in;
    sdr_pin_out_t       pin_out;
    logic               sck_w;
    logic               mosi_w;
    logic               peer_miso;
    logic               miso_w;
    logic               ss_w;
    logic               drv_sck;
    logic               drv_ss_n;
    logic               drv_mosi;
    logic [15:0]        slave_rx;
    logic [15:0]        peer_rx;
    int                 peer_frames;
    int                 mismatches;
    int                 n_checks;

    // Released lines fall to the peer, which idles the clock low, select high
    assign sck_w  = pin_out.sck_oe_n ? drv_sck : pin_out.sck;
    assign mosi_w = pin_out.mosi_oe_n ? drv_mosi : pin_out.mosi;
    assign miso_w = pin_out.miso_oe_n ? peer_miso : pin_out.miso;
    assign ss_w   = pin_out.ss_n & drv_ss_n;
    assign pin_in = {sck_w, mosi_w, miso_w, ss_w};

    sdr_spi_data i_dut (
        .clock(clock), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pin_in(pin_in),
        .pin_out(pin_out), .irq(irq)
    );

    sdr_peer #(.REPLY_BASE(16'h5a00), .REPLY_STEP(16'h0101)) i_peer (
        .sck(sck_w), .ss_n(ss_w), .mosi(mosi_w), .miso(peer_miso), .miso_line(miso_w),
        .drv_sck(drv_sck), .drv_ss_n(drv_ss_n), .drv_mosi(drv_mosi),
        .last_rx(peer_rx), .frames(peer_frames)
    );

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    function automatic logic [31:0] rxh(input int k);
        logic [15:0] w;
        w = 16'h5a00 + 16'h0101 * k[15:0];
        return {24'h0, w[15:8]};
    endfunction

    function automatic logic [31:0] rxl(input int k);
        logic [15:0] w;
        w = 16'h5a00 + 16'h0101 * k[15:0];
        return {24'h0, w[7:0]};
    endfunction

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic xfer(input logic wr, input logic [2:0] idx, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clock);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr  <= {27'h0, idx, 2'h0};
        do @(posedge clock); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clock); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wr(input logic [2:0] idx, input logic [7:0] d);
        logic [31:0] x;
        xfer(1'b1, idx, {24'h0, d}, x);
    endtask

    task automatic rdc(input string name, input logic [2:0] idx, input logic [31:0] exp);
        logic [31:0] x;
        xfer(1'b0, idx, 32'h0, x);
        chk(name, exp, x);
        chk("response", 32'h0, {31'h0, hresp});
    endtask

    // High byte is staged, low byte queues the word
    task automatic send(input logic [15:0] w);
        wr(`SDR_IDX_DHI, w[15:8]);
        wr(`SDR_IDX_DLO, w[7:0]);
    endtask

    task automatic wait_frames(input int n);
        int t;
        t = peer_frames + n;
        for (int i = 0; i < 4000 && peer_frames < t; i++) @(posedge clock);
        repeat (4) @(posedge clock);
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Clock, reset, watchdog
    // ------------------------------------------------------------
    always #10 clock = ~clock;

    initial begin
        repeat (20000) @(posedge clock);
        mismatches++;
        test_done;
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        clock = 1'b0; resetn = 1'b0; hsel = 1'b0; htrans = 2'h0;
        haddr = 32'h0; hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0;
        mismatches = 0; n_checks = 0;
        repeat (4) @(posedge clock);
        resetn <= 1'b1;
        // Reset state and an unmapped hole
        rdc("data high", `SDR_IDX_DHI, 32'h0);
        rdc("data low", `SDR_IDX_DLO, 32'h0);
        rdc("status", `SDR_IDX_STAT, 32'h20);
        rdc("unmapped", 3'h1, 32'h0);
        // One frame, interrupt masked then unmasked, then serviced
        wr(`SDR_IDX_CTRL, 8'h13);
        send(16'ha53c);
        wait_frames(1);
        chk("peer word", 32'ha53c, {16'h0, peer_rx});
        rdc("status", `SDR_IDX_STAT, 32'ha0);
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(`SDR_IDX_MASK, 8'h07);
        repeat (2) @(posedge clock);
        chk("irq raised", 32'h1, {31'h0, irq});
        rdc("irq status", `SDR_IDX_IRQ, 32'h3);
        repeat (2) @(posedge clock);
        chk("irq cleared", 32'h0, {31'h0, irq});
        rdc("irq status", `SDR_IDX_IRQ, 32'h0);
        rdc("data high", `SDR_IDX_DHI, rxh(0));
        rdc("status", `SDR_IDX_STAT, 32'ha0);
        rdc("data low", `SDR_IDX_DLO, rxl(0));
        rdc("status", `SDR_IDX_STAT, 32'h20);
        // Queued word back to back, second frame held unserviced
        send(16'h1234);
        send(16'h5678);
        rdc("status", `SDR_IDX_STAT, 32'h00);
        wait_frames(1);
        chk("peer word", 32'h1234, {16'h0, peer_rx});
        chk("next frame", 32'h0, {31'h0, pin_out.ss_n});
        wait_frames(1);
        chk("peer word", 32'h5678, {16'h0, peer_rx});
        rdc("status", `SDR_IDX_STAT, 32'ha1);
        rdc("data high", `SDR_IDX_DHI, rxh(1));
        rdc("data low", `SDR_IDX_DLO, rxl(1));
        rdc("status", `SDR_IDX_STAT, 32'ha0);
        rdc("data high", `SDR_IDX_DHI, rxh(2));
        rdc("data low", `SDR_IDX_DLO, rxl(2));
        rdc("status", `SDR_IDX_STAT, 32'h20);
        // Service only after a third frame has started
        rdc("irq status", `SDR_IDX_IRQ, 32'h3);
        send(16'h0f0f);
        send(16'hf0f0);
        wait_frames(1);
        send(16'h3c3c);
        wait_frames(1);
        rdc("status", `SDR_IDX_STAT, 32'ha0);
        rdc("data low", `SDR_IDX_DLO, rxl(3));
        rdc("status", `SDR_IDX_STAT, 32'h20);
        rdc("data high", `SDR_IDX_DHI, rxh(3));
        rdc("irq status", `SDR_IDX_IRQ, 32'h7);
        wait_frames(1);
        chk("peer word", 32'h3c3c, {16'h0, peer_rx});
        rdc("status", `SDR_IDX_STAT, 32'ha0);
        rdc("data high", `SDR_IDX_DHI, rxh(5));
        rdc("data low", `SDR_IDX_DLO, rxl(5));
        // Slave mode: peer clocks a word in and reads the queued one
        wr(`SDR_IDX_CTRL, 8'h01);
        send(16'h9669);
        i_peer.master_frame(16'hc3a5, slave_rx);
        chk("slave out", 32'h9669, {16'h0, slave_rx});
        repeat (4) @(posedge clock);
        rdc("status", `SDR_IDX_STAT, 32'ha0);
        rdc("data high", `SDR_IDX_DHI, 32'hc3);
        rdc("data low", `SDR_IDX_DLO, 32'ha5);
        test_done;
    end
endmodule
